// File: ltbw_pkg.sv
package ltbw_pkg;
  // ****************************************
  // Register map (word index, byte address is four times it)
  // ****************************************
  localparam logic [3:0] LTBW_IDX_CTRL = 4'hb;
  localparam logic [3:0] LTBW_IDX_CAPT = 4'hc;

  // ****************************************
  // Control/status bit positions
  // ****************************************
  localparam int LTBW_B_CAP_IE = 7;
  localparam int LTBW_B_CAP_FLAG = 6;
  localparam int LTBW_B_DOUBLE = 5;
  localparam int LTBW_B_TB_IE = 4;
  localparam int LTBW_B_TB_FLAG = 3;
  localparam int LTBW_B_FORCE = 2;
  localparam int LTBW_B_WDG_EN = 1;
  localparam int LTBW_B_WDG_DELAY = 0;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [7:0] LTBW_CAPT_RESET = 8'h00;
  localparam logic [7:0] LTBW_CNT_WRAP = 8'hf9;
  localparam int LTBW_PRESCALE = 32;
  localparam int LTBW_RESUME_CLKS = 256;
endpackage : ltbw_pkg

// File: ltbw_cnt_if.sv
`timescale 1ns/1ns
// Counter link between the register block and the divided counter
interface ltbw_cnt_if;
  logic freeze;
  logic wrap;
  logic [7:0] count;
  modport ctrl (output freeze, input wrap, input count);
  modport cnt (input freeze, output wrap, output count);
endinterface : ltbw_cnt_if

// File: ltbw_counter.sv
`timescale 1ns/1ns
// Oscillator divided by the prescale, then an 8-bit count with early wrap
module ltbw_counter
  import ltbw_pkg::*;
#(
  parameter int PRESCALE = LTBW_PRESCALE,
  parameter logic [7:0] WRAP_AT = LTBW_CNT_WRAP
) (
  input wire logic clk_i,   // Oscillator clock
  input wire logic rst_n_i, // Synchronous reset, active low
  ltbw_cnt_if.cnt link      // Freeze in, count and wrap out
);
  localparam int PW = $clog2(PRESCALE);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

  logic [PW-1:0] pre_r;
  logic [7:0] count_r;
  logic wrap_r;

  // ****************************************
  // Prescaler
  // ****************************************
  // divide by prescale
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_r <= '0;
    end else if (!link.freeze) begin
      pre_r <= (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  // wrap at limit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_r <= 8'h00;
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= 1'b0;
      if (!link.freeze && pre_r == PRE_LAST) begin
        if (count_r == WRAP_AT) begin
          count_r <= 8'h00;
          wrap_r <= 1'b1;
        end else begin
          count_r <= count_r + 8'h01;
        end
      end
    end
  end

  assign link.count = count_r;
  assign link.wrap = wrap_r;
endmodule : ltbw_counter

// File: ltbw_timer.sv
`timescale 1ns/1ns
// What this block does
// - counter from zero at clock over 32
// - counter wraps F9h to 00h, overflow event
// - timebase 8000 or 16000 clocks by select
// - overflow sets timebase flag, irq if enabled
// - control read clears timebase flag, writes ignored
// - enabled watchdog resets after unrefreshed period
// - software sets delay, hardware clears each period
// - period counts from reset, late enable resets
// - enable then set force bit forces reset
// - force bit set by watchdog, cleared by LVD
// - force bit still set at enable resets
// - hardware option makes watchdog always active
// - option makes halt produce watchdog reset while watchdog active
// - halt freezes counter, no watchdog reset unless halt option set
// - wake resumes watchdog after 256 clocks
// - input edge captures count and sets flag
// - flag blocks capture, capture read clears
// - capture register read-only, resets to zero
// - only halt and the 256-clock resume after it stop counter, other modes not
// - timebase wakes wait, capture wakes halt
// - two request lines, gated by global mask
// - control bit order fixed, resets zero except force bit on MCU reset
module ltbw_timer
  import ltbw_pkg::*;
#(
  parameter int RESUME_CLKS = LTBW_RESUME_CLKS
) (
  input wire logic clk_i,             // Oscillator clock, 25 MHz
  input wire logic rst_n_i,           // MCU reset, synchronous, active low
  input wire logic lvd_rst_n_i,       // Low-voltage reset, synchronous, active low
  input wire logic wb_cyc_i,          // Wishbone cycle
  input wire logic wb_stb_i,          // Wishbone strobe
  input wire logic wb_we_i,           // Wishbone write enable
  input wire logic [7:0] wb_adr_i,    // Wishbone byte address
  input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic [31:0] wb_dat_o,       // Wishbone read data
  output logic wb_ack_o,              // Wishbone acknowledge
  input wire logic capture_input_pin_i, // Asynchronous capture pin
  input wire logic hw_wdg_opt_i,      // Option: watchdog always on
  input wire logic halt_reset_opt_i,  // Option: halt causes watchdog reset
  input wire logic halt_i,            // CPU in halt, oscillator stopped
  input wire logic wait_i,            // CPU in wait or active halt
  input wire logic irq_mask_i,        // CPU global interrupt mask
  output logic tb_irq_o,              // Timebase interrupt request
  output logic cap_irq_o,             // Capture interrupt request
  output logic wake_o,                // Wake request toward the CPU
  output logic wdg_reset_o            // Watchdog device reset request
);
  localparam int RW = $clog2(RESUME_CLKS + 1);
  localparam logic [RW-1:0] RESUME_LOAD = RW'(RESUME_CLKS);

  ltbw_cnt_if cnt_link ();

  // ****************************************
  // Register state
  // ****************************************
  logic capture_irq_enable_r;
  logic capture_flag_r;
  logic period_double_select_r;
  logic timebase_irq_enable_r;
  logic timebase_flag_r;
  logic watchdog_force_status_r;
  logic watchdog_enable_r;
  logic watchdog_delay_r;
  logic [7:0] captured_count_r;
  logic status_read_r;

  // Watchdog and halt bookkeeping
  logic phase_r;
  logic expired_r;
  logic halt_q_r;
  logic [RW-1:0] resume_r;

  // Capture pin synchroniser and edge memory
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;

  // Bus decode
  logic bus_req;
  logic acc_ctrl;
  logic acc_capt;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_capt;
  logic period_end;
  logic tb_event;
  logic cap_edge;
  logic wdg_active;
  logic wdg_blocked;
  logic wdg_fire;
  logic [7:0] ctrl_view;

  // ****************************************
  // Divided counter
  // ****************************************
  // halt freezes count
  assign cnt_link.freeze = halt_i || (resume_r != '0);

  ltbw_counter #(
    .PRESCALE(LTBW_PRESCALE),
    .WRAP_AT(LTBW_CNT_WRAP)
  ) u_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .link(cnt_link.cnt)
  );

  // ****************************************
  // Wishbone decode
  // ****************************************
  // Single-cycle answer; side effects happen on the acked edge only
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign acc_ctrl = bus_req && (wb_adr_i[5:2] == LTBW_IDX_CTRL);
  assign acc_capt = bus_req && (wb_adr_i[5:2] == LTBW_IDX_CAPT);
  assign wr_ctrl = acc_ctrl && wb_we_i && wb_sel_i[0];
  assign rd_ctrl = acc_ctrl && !wb_we_i;
  assign rd_capt = acc_capt && !wb_we_i;

  assign ctrl_view = {capture_irq_enable_r, capture_flag_r, period_double_select_r,
                      timebase_irq_enable_r, timebase_flag_r, watchdog_force_status_r,
                      watchdog_enable_r, watchdog_delay_r};

  // Ack one cycle after the request, drop it the cycle after
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data; unmapped words read as zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      if (acc_ctrl) begin
        wb_dat_o <= {24'h00_0000, ctrl_view};
      end else if (acc_capt) begin
        wb_dat_o <= {24'h00_0000, captured_count_r};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Software-owned control bits
  // ****************************************
  // reset to zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      capture_irq_enable_r <= 1'b0;
      period_double_select_r <= 1'b0;
      timebase_irq_enable_r <= 1'b0;
      watchdog_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      capture_irq_enable_r <= wb_dat_i[LTBW_B_CAP_IE];
      period_double_select_r <= wb_dat_i[LTBW_B_DOUBLE];
      timebase_irq_enable_r <= wb_dat_i[LTBW_B_TB_IE];
      watchdog_enable_r <= wb_dat_i[LTBW_B_WDG_EN];
    end
  end

  // ****************************************
  // Timebase
  // ****************************************
  // Phase splits each pair of wraps; it starts at reset, so the
  // watchdog period is counted from reset even while disabled.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_r <= 1'b0;
    end else if (cnt_link.wrap) begin
      phase_r <= !phase_r;
    end
  end

  assign tb_event = cnt_link.wrap && (!period_double_select_r || phase_r);
  assign period_end = cnt_link.wrap && phase_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timebase_flag_r <= 1'b0;
    end else if (tb_event) begin
      timebase_flag_r <= 1'b1;
    end else if (rd_ctrl) begin
      timebase_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  // software set, period clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watchdog_delay_r <= 1'b0;
    end else if (wr_ctrl && wb_dat_i[LTBW_B_WDG_DELAY]) begin
      watchdog_delay_r <= 1'b1;
    end else if (period_end) begin
      watchdog_delay_r <= 1'b0;
    end
  end

  // unrefreshed period remembered
  // A refresh clears it, so setting delay before enable avoids a reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      expired_r <= 1'b0;
    end else if (wr_ctrl && wb_dat_i[LTBW_B_WDG_DELAY]) begin
      expired_r <= 1'b0;
    end else if (period_end && !watchdog_delay_r) begin
      expired_r <= 1'b1;
    end
  end

  // resume delay after wake
  // Wake by reset is covered by the reset branch: counter idle, enable low
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      halt_q_r <= 1'b0;
      resume_r <= '0;
    end else begin
      halt_q_r <= halt_i;
      if (halt_q_r && !halt_i) begin
        resume_r <= RESUME_LOAD;
      end else if (resume_r != '0) begin
        resume_r <= resume_r - 1'b1;
      end
    end
  end

  assign wdg_active = hw_wdg_opt_i || watchdog_enable_r;
  assign wdg_blocked = cnt_link.freeze;
  assign wdg_fire = (wdg_active && !wdg_blocked && (expired_r || watchdog_force_status_r))
                    || (wdg_active && halt_reset_opt_i && halt_i);

  // Held until the MCU reset arrives, so it cannot be missed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wdg_reset_o <= 1'b0;
    end else if (wdg_fire) begin
      wdg_reset_o <= 1'b1;
    end
  end

  // Arms a software clear of the force bit after a control read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_read_r <= 1'b0;
    end else if (rd_ctrl) begin
      status_read_r <= 1'b1;
    end else if (wr_ctrl) begin
      status_read_r <= 1'b0;
    end
  end

  // survives MCU reset
  // The low-voltage reset or a control write with bit 2 at zero after a control read clears it, so software can see the cause
  always_ff @(posedge clk_i) begin
    if (!lvd_rst_n_i) begin
      watchdog_force_status_r <= 1'b0;
    end else if (wdg_fire) begin
      watchdog_force_status_r <= 1'b1;
    end else if (wr_ctrl && wb_dat_i[LTBW_B_FORCE]) begin
      watchdog_force_status_r <= 1'b1;
    end else if (wr_ctrl && status_read_r) begin
      watchdog_force_status_r <= 1'b0;
    end
  end

  // ****************************************
  // Input capture
  // ****************************************
  // Two stages before use; the third only remembers the last level.
  // No reset: a pin held high through reset must not look like an edge
  always_ff @(posedge clk_i) begin
    pin_s1_r <= capture_input_pin_i;
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  assign cap_edge = pin_s2_r ^ pin_s3_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      captured_count_r <= LTBW_CAPT_RESET;
    end else if (cap_edge && !capture_flag_r) begin
      captured_count_r <= cnt_link.count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      capture_flag_r <= 1'b0;
    end else if (cap_edge && !capture_flag_r) begin
      capture_flag_r <= 1'b1;
    end else if (rd_capt) begin
      capture_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt requests and wake
  // ****************************************
  // separate lines, masked
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tb_irq_o <= 1'b0;
      cap_irq_o <= 1'b0;
    end else begin
      tb_irq_o <= timebase_flag_r && timebase_irq_enable_r && !irq_mask_i;
      cap_irq_o <= capture_flag_r && capture_irq_enable_r && !irq_mask_i;
    end
  end

  // wake sources by mode
  // Timebase cannot wake halt; capture wakes halt but not active halt
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_o <= 1'b0;
    end else if (halt_i) begin
      wake_o <= capture_flag_r && capture_irq_enable_r;
    end else if (wait_i) begin
      wake_o <= timebase_flag_r && timebase_irq_enable_r;
    end else begin
      wake_o <= 1'b0;
    end
  end
endmodule : ltbw_timer

// File: ltbw_timer_props.sv
`timescale 1ns/1ns
// ******
// Port checker for the timer top
// ******
module ltbw_timer_props (
  input wire logic clk_i,            // Clock
  input wire logic rst_n_i,          // Reset, active low
  input wire logic wb_cyc_i,         // Bus cycle
  input wire logic wb_stb_i,         // Bus strobe
  input wire logic [31:0] wb_dat_o,  // Read data
  input wire logic wb_ack_o,         // Acknowledge
  input wire logic hw_wdg_opt_i,     // Watchdog always on
  input wire logic halt_reset_opt_i, // Halt resets
  input wire logic halt_i,           // Halt level
  input wire logic wait_i,           // Wait level
  input wire logic irq_mask_i,       // Global mask
  input wire logic tb_irq_o,         // Timebase request
  input wire logic cap_irq_o,        // Capture request
  input wire logic wake_o,           // Wake request
  input wire logic wdg_reset_o       // Watchdog reset
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_tb_masked: assert property (irq_mask_i |=> !tb_irq_o)
    else $error("timebase request while masked");
  a_cap_masked: assert property (irq_mask_i |=> !cap_irq_o)
    else $error("capture request while masked");
  a_wdg_sticky: assert property (wdg_reset_o |=> wdg_reset_o)
    else $error("watchdog reset dropped early");
  a_halt_reset: assert property ((hw_wdg_opt_i && halt_reset_opt_i && halt_i) |=> wdg_reset_o)
    else $error("halt did not reset");
  // Two cycles of halt so a late freeze cannot trip it
  a_halt_quiet: assert property ((halt_i && $past(halt_i, 2) && !halt_reset_opt_i
    && !wdg_reset_o) |=> !wdg_reset_o)
    else $error("watchdog fired in halt");
  a_idle_wake: assert property ((!halt_i && !wait_i) |=> !wake_o)
    else $error("wake outside low power");
endmodule : ltbw_timer_props

bind ltbw_timer ltbw_timer_props u_props (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .hw_wdg_opt_i, .halt_reset_opt_i, .halt_i, .wait_i,
  .irq_mask_i, .tb_irq_o, .cap_irq_o, .wake_o, .wdg_reset_o);

// File: ltbw_pin_model.sv
`timescale 1ns/1ns
// ******
// Capture pin driver
// ******
module ltbw_pin_model (
  input wire logic clk_i, // Clock
  output logic pin_o      // Capture pin level
);
  // Pin idles low so the first edge is a rising one
  initial pin_o = 1'b0;

  task automatic edge_after(input int d);
    repeat (d) @(posedge clk_i);
    pin_o <= ~pin_o;
  endtask : edge_after
endmodule : ltbw_pin_model

// File: ltbw_timer_bench.sv
`timescale 1ns/1ns
module ltbw_timer_bench import ltbw_pkg::*; ;
  logic clk_i;
  logic rst_n_i, lvd_rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, capture_input_pin_i;
  logic hw_wdg_opt_i, halt_reset_opt_i, halt_i, wait_i, irq_mask_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic wb_ack_o, tb_irq_o, cap_irq_o, wake_o, wdg_reset_o;
  logic [3:0] mon;
  logic [7:0] q, v;
  int miscompares, total_checks, cyc_n, r0, t, t1, n, e;
  localparam logic [7:0] A_CTRL = {2'b00, LTBW_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_CAPT = {2'b00, LTBW_IDX_CAPT, 2'b00};

  assign mon = {wake_o, wdg_reset_o, cap_irq_o, tb_irq_o};

  ltbw_timer #(.RESUME_CLKS(LTBW_RESUME_CLKS)) DUT (.clk_i, .rst_n_i, .lvd_rst_n_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .capture_input_pin_i, .hw_wdg_opt_i, .halt_reset_opt_i, .halt_i,
    .wait_i, .irq_mask_i, .tb_irq_o, .cap_irq_o, .wake_o, .wdg_reset_o);
  ltbw_pin_model u_pin (.clk_i, .pin_o(capture_input_pin_i));

  // 25 MHz clock and a free cycle count for the model
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  // ******
  // Model, checks and bus
  // ******
  // Counter value the model expects at a given cycle
  function automatic int cnt_at(input int c);
    return ((c - r0) / LTBW_PRESCALE) % (int'(LTBW_CNT_WRAP) + 1);
  endfunction : cnt_at

  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    // The ack ends this wait, or the hang guard if no ack comes
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task wt(input int i, input int lim);
    n = 0;
    while (mon[i] !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    t = cyc_n;
  endtask : wt

  task do_rst(input logic lvd);
    rst_n_i <= 1'b0;
    lvd_rst_n_i <= !lvd;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    lvd_rst_n_i <= 1'b1;
    @(posedge clk_i);
    r0 = cyc_n;
  endtask : do_rst

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // Hang guard, some margin above the roughly 82k cycles the tests take
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    print_verdict;
  end

  // ******
  // Test sequence
  // ******
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, hw_wdg_opt_i, halt_reset_opt_i} = 5'h0;
    {halt_i, wait_i, irq_mask_i, rst_n_i, lvd_rst_n_i} = 5'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    void'($urandom(24));
    do_rst(1'b1);
    v = 8'($urandom);
    bus(0, A_CTRL, 0); chk(q, 8'h00);
    bus(0, A_CAPT, 0); chk(q, LTBW_CAPT_RESET);
    bus(1, A_CAPT, v); bus(0, A_CAPT, 0); chk(q, 8'h00);
    bus(1, A_CTRL, v & 8'hb8); bus(0, A_CTRL, 0); chk(q, v & 8'hb0);
    bus(1, 8'h00, v); bus(0, 8'h00, 0); chk(q, 8'h00);
    $display("test 1 done");
    bus(1, A_CTRL, 8'h80);
    u_pin.edge_after(40 + $urandom % 200);
    wt(1, 100); chk(cap_irq_o, 1);
    e = cnt_at(t - 2);
    bus(0, A_CTRL, 0); chk(q, 8'hc0);
    // Blocked edge lands over a count step later, so an overwrite would show
    u_pin.edge_after(40);
    repeat (100) @(posedge clk_i);
    bus(0, A_CAPT, 0); chk(q, e);
    bus(0, A_CTRL, 0); chk(q, 8'h80);
    halt_i <= 1'b1;
    // The counter still steps on this edge, then stays frozen
    e = cnt_at(cyc_n + 1);
    u_pin.edge_after(200);
    wt(3, 100); chk(wake_o, 1);
    bus(0, A_CAPT, 0); chk(q, e);
    halt_i <= 1'b0;
    $display("test 2 done");
    wait_i <= 1'b1;
    bus(1, A_CTRL, 8'h10);
    wt(0, 9000); t1 = t;
    repeat (2) @(posedge clk_i); chk(wake_o, 1);
    irq_mask_i <= 1'b1;
    repeat (3) @(posedge clk_i); chk(tb_irq_o, 0);
    irq_mask_i <= 1'b0;
    repeat (3) @(posedge clk_i); chk(tb_irq_o, 1);
    bus(0, A_CTRL, 0); chk(q, 8'h18);
    repeat (3) @(posedge clk_i); chk(tb_irq_o, 0);
    wt(0, 9000); chk(t - t1, 8000);
    t1 = t;
    bus(1, A_CTRL, 8'h30); bus(0, A_CTRL, 0); chk(q, 8'h38);
    // The request lags the clearing read by a cycle; let it fall first
    repeat (2) @(posedge clk_i);
    wt(0, 17000); chk(t - t1, 16000);
    bus(0, A_CTRL, 0); chk(q, 8'h38);
    wait_i <= 1'b0;
    $display("test 3 done");
    do_rst(1'b0);
    for (int i = 0; i < 4; i++) begin
      bus(1, A_CTRL, 8'h03);
      repeat (5000) @(posedge clk_i);
    end
    bus(0, A_CTRL, 0); chk(q, 8'h0a);
    chk(wdg_reset_o, 0);
    wt(2, 15000); chk(wdg_reset_o, 1);
    chk((t - r0 + 50) / 100, 320);
    do_rst(1'b0);
    bus(0, A_CTRL, 0); chk(q, 8'h04);
    // Rewriting the set bit disarms the read, so the flag survives the enable
    bus(1, A_CTRL, 8'h04); bus(1, A_CTRL, 8'h02); wt(2, 5); chk(wdg_reset_o, 1);
    do_rst(1'b0);
    bus(0, A_CTRL, 0); bus(1, A_CTRL, 0); bus(0, A_CTRL, 0); chk(q, 8'h00);
    bus(1, A_CTRL, 8'h02); chk(wdg_reset_o, 0);
    bus(1, A_CTRL, 8'h06); wt(2, 5); chk(wdg_reset_o, 1);
    do_rst(1'b1);
    bus(0, A_CTRL, 0); chk(q, 8'h00);
    repeat (17000) @(posedge clk_i);
    bus(1, A_CTRL, 8'h02); wt(2, 5); chk(wdg_reset_o, 1);
    do_rst(1'b1);
    hw_wdg_opt_i <= 1'b1;
    halt_reset_opt_i <= 1'b1;
    halt_i <= 1'b1;
    wt(2, 5); chk(wdg_reset_o, 1);
    $display("test 4 done");
    print_verdict;
  end
endmodule : ltbw_timer_bench
